// file: src/sck_rate_gen.sv
`timescale 1ns/1ns
module sck_rate_gen
   import sync_serial_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Rate control
   sck_rate_if.gen rif
);

   // All state of the divider
   typedef struct packed {
      logic [8:0] cnt;
      logic tick;
   } gen_state_t;

   gen_state_t gen_ff;   // Registered state
   gen_state_t nxt_gen;  // Next state

   // Half period counter, reloaded while idle so the first edge is a full half late
   always_comb begin
      nxt_gen = gen_ff;
      nxt_gen.tick = 1'b0;
      if (!rif.run) begin
         nxt_gen.cnt = half_reload(rif.mode, rif.reload);
      end else if (rif.mode == MODE_TMR) begin
         // Each timer match toggles the serial clock once
         nxt_gen.tick = rif.tmr_match;
      end else if (gen_ff.cnt == RST_RATE_CNT) begin
         // Divide by 4, 16, 64 or 4*(reload+1)
         nxt_gen.tick = 1'b1;
         nxt_gen.cnt = half_reload(rif.mode, rif.reload);
      end else begin
         nxt_gen.cnt = gen_ff.cnt - 9'h001;
      end
   end

   // State register
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         gen_ff <= '0;
      end else begin
         gen_ff <= nxt_gen;
      end
   end

   assign rif.tick = gen_ff.tick;

   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);

   // Timer rate follows each match pulse one cycle later
   a_timer_tick_rate: assert property ((rif.run && rif.mode == MODE_TMR && rif.tmr_match) |=> rif.tick)
      else $error("timer match did not produce a tick");

endmodule : sck_rate_gen

// file: src/sck_rate_if.sv
`timescale 1ns/1ns
interface sck_rate_if;
   logic [3:0] mode;    // Clock rate selection
   logic [7:0] reload;  // Baud reload value
   logic run;           // Transfer in progress
   logic tmr_match;     // Timer match pulse
   logic tick;          // Half period elapsed

   modport gen(input mode, input reload, input run, input tmr_match, output tick);
   modport user(output mode, output reload, output run, output tmr_match, input tick);
endinterface : sck_rate_if

// file: src/sync_serial_pkg.sv
package sync_serial_pkg;

   // Register byte offsets on the bus
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_CTRL1 = 8'h04;
   localparam logic [7:0] OFS_CTRL3 = 8'h08;
   localparam logic [7:0] OFS_BUF = 8'h0C;
   localparam logic [7:0] OFS_BAUD = 8'h10;
   localparam logic [7:0] OFS_FLAGS = 8'h14;

   // Field positions of serial_port_status
   localparam int STAT_SAMPLE_PH = 7;
   localparam int STAT_CKE = 6;
   localparam int STAT_FULL = 0;
   // Field positions of port_control_one
   localparam int C1_COLLIDE = 7;
   localparam int C1_EN = 5;
   localparam int C1_IDLE_POL = 4;
   localparam int C1_MODE_LSB = 0;
   // Field positions of port_control_three and the flag register
   localparam int C3_SDO_OFF = 0;
   localparam int FLG_IF = 0;

   // Values after reset
   localparam logic [3:0] RST_MODE = 4'h0;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] RST_BITCNT = 3'h0;
   localparam logic [8:0] RST_RATE_CNT = 9'h000;

   // Mode field encodings
   localparam logic [3:0] MODE_DIV4 = 4'h0;
   localparam logic [3:0] MODE_DIV16 = 4'h1;
   localparam logic [3:0] MODE_DIV64 = 4'h2;
   localparam logic [3:0] MODE_TMR = 4'h3;
   localparam logic [3:0] MODE_SLV_SS = 4'h4;
   localparam logic [3:0] MODE_SLV_NOSS = 4'h5;
   localparam logic [3:0] MODE_BAUD = 4'hA;

   // Core cycles per half serial clock period, minus one
   localparam logic [8:0] HALF_DIV4 = 9'h001;
   localparam logic [8:0] HALF_DIV16 = 9'h007;
   localparam logic [8:0] HALF_DIV64 = 9'h01F;
   localparam logic [2:0] LAST_BIT = 3'h7;

   // Transfer engine states
   typedef enum logic [2:0] {
      ST_OFF = 3'b001,
      ST_IDLE = 3'b010,
      ST_XFER = 3'b100
   } xfer_state_t;

   // Master role decode
   function automatic logic is_master(input logic [3:0] mode);
      is_master = (mode == MODE_DIV4) || (mode == MODE_DIV16) || (mode == MODE_DIV64)
         || (mode == MODE_TMR) || (mode == MODE_BAUD);
   endfunction : is_master

   // Half period reload for the divider modes
   function automatic logic [8:0] half_reload(input logic [3:0] mode, input logic [7:0] baud);
      case (mode)
         MODE_DIV16: half_reload = HALF_DIV16;
         MODE_DIV64: half_reload = HALF_DIV64;
         MODE_BAUD: half_reload = {baud, 1'b1};
         default: half_reload = HALF_DIV4;
      endcase
   endfunction : half_reload

endpackage : sync_serial_pkg

// file: src/sync_serial_port.sv
`timescale 1ns/1ns
module sync_serial_port
   import sync_serial_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic o_wb_ack,
   output logic [31:0] o_wb_dat,
   // Serial clock pin
   input wire logic i_sck,
   output logic o_sck,
   output logic o_sck_oe,
   // Serial data pins
   input wire logic i_sdi,
   output logic o_sdo,
   output logic o_sdo_oe,
   // Slave select pin
   input wire logic i_ss_b,
   // Timer match pulse, same clock
   input wire logic i_tmr_match,
   // Interrupt flag level
   output logic o_port_int_flag
);

   // All state of the port
   typedef struct packed {
      xfer_state_t fsm;
      logic ack;
      logic [31:0] rdat;
      logic collide;
      logic en;
      logic idle_pol;
      logic [3:0] mode;
      logic sample_ph;
      logic cke;
      logic full;
      logic iflag;
      logic sdo_off;
      logic [7:0] baud;
      logic [7:0] buf_q;
      logic [7:0] shreg;
      logic in_bit;
      logic [2:0] bitcnt;
      logic sck;
      logic sck_oe;
      logic sdo;
      logic sdo_oe;
      logic sck_m;
      logic sck_s;
      logic sck_prev;
      logic sdi_m;
      logic sdi_s;
      logic ss_m;
      logic ss_s;
   } port_state_t;

   port_state_t st_ff;   // Registered state
   port_state_t nxt_st;  // Next state

   sck_rate_if rif();    // Link to the rate generator

   // Rate generator
   sck_rate_gen u_sck_rate_gen (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .rif(rif.gen)
   );

   logic master;      // Master role selected
   logic slave_ss;    // Slave with select control
   logic selected;    // Slave addressed or select unused
   logic busy;        // Byte in flight
   logic edge_any;    // Serial clock edge this cycle
   logic edge_a;      // Edge leaving idle level
   logic edge_b;      // Edge returning to idle level
   logic cap_a;       // Sample on the leaving edge
   logic req;         // New bus request
   logic wr;          // Bus write, low lane enabled
   logic rd;          // Bus read
   logic buf_wr_ok;   // Buffer write accepted
   logic done;        // Last bit shifted in
   logic [7:0] d;     // Write data low byte
   logic [7:0] shin;  // Shift register after shift

   // Hook up the rate generator
   always_comb begin
      rif.mode = st_ff.mode;
      rif.reload = st_ff.baud;
      rif.run = master && (st_ff.fsm == ST_XFER);
      rif.tmr_match = i_tmr_match;
   end

   // Role and edge decode
   always_comb begin
      master = is_master(st_ff.mode);
      slave_ss = (st_ff.mode == MODE_SLV_SS);
      selected = !slave_ss || !st_ff.ss_s;
      busy = (st_ff.fsm == ST_XFER);
      if (master) begin
         // Own clock edges come from the rate generator
         edge_any = busy && rif.tick;
         edge_a = edge_any && (st_ff.sck == st_ff.idle_pol);
      end else begin
         // Foreign clock only counts while selected
         edge_any = st_ff.en && selected && (st_ff.fsm != ST_OFF)
            && (st_ff.sck_s != st_ff.sck_prev);
         edge_a = edge_any && (st_ff.sck_s != st_ff.idle_pol);
      end
      edge_b = edge_any && !edge_a;
      // Sample middle with clock-edge set and phase clear, else at the shift edge
      cap_a = st_ff.cke && !st_ff.sample_ph;
      shin = {st_ff.shreg[6:0], cap_a ? st_ff.in_bit : st_ff.sdi_s};
      done = edge_b && (st_ff.bitcnt == LAST_BIT);
      req = i_wb_cyc && i_wb_stb && !st_ff.ack;
      wr = req && i_wb_we && i_wb_sel[0];
      rd = req && !i_wb_we;
      d = i_wb_dat[7:0];
      // Writes during a transfer or with collision pending never land
      buf_wr_ok = wr && (i_wb_adr == OFS_BUF) && !busy && !st_ff.collide && st_ff.en;
   end

   // Next state: bus side first, then hardware events so a set beats a clear
   always_comb begin
      nxt_st = st_ff;
      // Two-stage synchronisers for the pins
      nxt_st.sck_m = i_sck;
      nxt_st.sck_s = st_ff.sck_m;
      nxt_st.sck_prev = st_ff.sck_s;
      nxt_st.sdi_m = i_sdi;
      nxt_st.sdi_s = st_ff.sdi_m;
      nxt_st.ss_m = i_ss_b;
      nxt_st.ss_s = st_ff.ss_m;

      // Bus answer one cycle after the request
      nxt_st.ack = req;
      if (rd) begin
         case (i_wb_adr)
            OFS_STATUS: nxt_st.rdat = {24'h000000, st_ff.sample_ph, st_ff.cke, 5'h00,
               st_ff.full};
            OFS_CTRL1: nxt_st.rdat = {24'h000000, st_ff.collide, 1'b0, st_ff.en,
               st_ff.idle_pol, st_ff.mode};
            OFS_CTRL3: nxt_st.rdat = {31'h00000000, st_ff.sdo_off};
            OFS_BUF: nxt_st.rdat = {24'h000000, st_ff.buf_q};
            OFS_BAUD: nxt_st.rdat = {24'h000000, st_ff.baud};
            OFS_FLAGS: nxt_st.rdat = {31'h00000000, st_ff.iflag};
            default: nxt_st.rdat = 32'h00000000;   // Unmapped reads as zero
         endcase
      end
      // Reading the buffer empties it
      if (rd && (i_wb_adr == OFS_BUF)) begin
         nxt_st.full = 1'b0;
      end

      if (wr) begin
         case (i_wb_adr)
            OFS_STATUS: begin
               // Only the two top bits take writes
               nxt_st.sample_ph = d[STAT_SAMPLE_PH];
               nxt_st.cke = d[STAT_CKE];
            end
            OFS_CTRL1: begin
               nxt_st.collide = d[C1_COLLIDE];
               nxt_st.en = d[C1_EN];
               nxt_st.idle_pol = d[C1_IDLE_POL];
               nxt_st.mode = d[C1_MODE_LSB +: 4];
            end
            OFS_CTRL3: nxt_st.sdo_off = d[C3_SDO_OFF];
            OFS_BAUD: nxt_st.baud = d;
            OFS_FLAGS: begin
               // Write one to clear the interrupt flag
               if (d[FLG_IF]) begin
                  nxt_st.iflag = 1'b0;
               end
            end
            default: begin
               // Buffer handled below, unmapped writes ignored
            end
         endcase
      end

      // Buffer write: shift register only reachable this way
      if (buf_wr_ok) begin
         nxt_st.buf_q = d;
         nxt_st.shreg = d;
         nxt_st.bitcnt = RST_BITCNT;
         // Data valid before the first edge when clock-edge is set
         if (st_ff.cke) begin
            nxt_st.sdo = d[7];
         end
         // Master starts at once
         if (master) begin
            nxt_st.fsm = ST_XFER;
         end
      end else if (wr && (i_wb_adr == OFS_BUF) && busy) begin
         nxt_st.collide = 1'b1;
      end

      // Shift engine
      if (edge_any && !master && (st_ff.fsm == ST_IDLE)) begin
         nxt_st.fsm = ST_XFER;
      end
      if (master && edge_any) begin
         nxt_st.sck = !st_ff.sck;
      end
      if (edge_a) begin
         if (cap_a) begin
            nxt_st.in_bit = st_ff.sdi_s;
         end
         // Without clock-edge the bit appears on the leaving edge
         if (!st_ff.cke) begin
            nxt_st.sdo = st_ff.shreg[7];
         end
      end
      if (edge_b) begin
         nxt_st.shreg = shin;
         nxt_st.bitcnt = 3'(st_ff.bitcnt + 3'h1);
         if (st_ff.cke) begin
            nxt_st.sdo = st_ff.shreg[6];
         end
      end
      if (done) begin
         // Byte complete: copy out and flag, even with output off
         nxt_st.buf_q = shin;
         nxt_st.full = 1'b1;
         nxt_st.iflag = 1'b1;
         nxt_st.fsm = ST_IDLE;
         nxt_st.bitcnt = RST_BITCNT;
      end

      // Select released in select mode resets the byte
      if (!master && slave_ss && st_ff.ss_s) begin
         nxt_st.bitcnt = RST_BITCNT;
         if (st_ff.fsm == ST_XFER) begin
            nxt_st.fsm = ST_IDLE;
         end
      end
      // Idle clock parks at the polarity level
      if (nxt_st.fsm != ST_XFER) begin
         nxt_st.sck = nxt_st.idle_pol;
      end
      // Disable is the port reset
      if (!nxt_st.en) begin
         nxt_st.fsm = ST_OFF;
         nxt_st.bitcnt = RST_BITCNT;
      end else if (st_ff.fsm == ST_OFF) begin
         nxt_st.fsm = ST_IDLE;
      end
      // Pin drivers: the pin direction bits live outside this block
      nxt_st.sck_oe = nxt_st.en && is_master(nxt_st.mode);
      nxt_st.sdo_oe = nxt_st.en && !nxt_st.sdo_off
         && (is_master(nxt_st.mode) || (nxt_st.mode != MODE_SLV_SS) || !st_ff.ss_s);
   end

   // State register
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_ff <= '{fsm: ST_OFF, mode: RST_MODE, baud: RST_BYTE, buf_q: RST_BYTE,
            shreg: RST_BYTE, bitcnt: RST_BITCNT, rdat: 32'h00000000, ss_m: 1'b1,
            ss_s: 1'b1, default: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from flops
   assign o_wb_ack = st_ff.ack;
   assign o_wb_dat = st_ff.rdat;
   assign o_sck = st_ff.sck;
   assign o_sck_oe = st_ff.sck_oe;
   assign o_sdo = st_ff.sdo;
   assign o_sdo_oe = st_ff.sdo_oe;
   assign o_port_int_flag = st_ff.iflag;

   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);

   // Clock-edge mode shows the MSb right after the load
   a_msb_before_edge: assert property ((buf_wr_ok && st_ff.cke) |=> (o_sdo == $past(d[7])))
      else $error("msb not presented before first edge");

   // Master load starts a transfer next cycle
   a_master_starts: assert property ((buf_wr_ok && master) |=> (busy && st_ff.bitcnt == 3'h0))
      else $error("master write did not start transfer");

   // Completed byte lands in the buffer with both flags
   a_rx_byte_flags: assert property (done |=> (st_ff.full && st_ff.iflag && st_ff.buf_q == $past(shin)))
      else $error("received byte not posted");

   // Write during a transfer leaves buffer untouched and flags collision
   a_collision_flag: assert property ((wr && i_wb_adr == OFS_BUF && busy && !done)
      |=> (st_ff.collide && $stable(st_ff.buf_q)))
      else $error("collision write not discarded");

   // Pending collision blocks the load
   a_collision_blocks: assert property ((wr && i_wb_adr == OFS_BUF && st_ff.collide && !done)
      |=> $stable(st_ff.buf_q))
      else $error("write landed with collision pending");

   // Buffer read empties the full flag unless a byte arrives
   a_read_clears_full: assert property ((rd && i_wb_adr == OFS_BUF && !done) |=> !st_ff.full)
      else $error("buffer read kept full flag");

   // Select release floats data and resets the counter
   a_ss_release_float: assert property ((st_ff.en && slave_ss && st_ff.ss_s && !wr)
      |=> (!o_sdo_oe && st_ff.bitcnt == 3'h0))
      else $error("select release did not float output");

   // Disable forces the counter to zero
   a_disable_reset: assert property (!st_ff.en |-> (st_ff.bitcnt == 3'h0 && st_ff.fsm == ST_OFF))
      else $error("disabled port holds bit count");

   // Clock pin direction follows the role
   a_sck_role: assert property ((st_ff.en && st_ff.sck_oe) |-> master)
      else $error("clock driven outside master role");

   // Master clock idles at polarity between bytes
   a_sck_idle_level: assert property ((master && st_ff.en && !busy && $stable(st_ff.idle_pol))
      |-> (o_sck == st_ff.idle_pol))
      else $error("idle clock off polarity");

endmodule : sync_serial_port

// file: tb/spi_far_end.sv
`timescale 1ns/1ns
module spi_far_end (
   // Core clock and role
   input wire logic i_core_clk,
   input wire logic i_role_master,
   // Lines from the port
   input wire logic i_sck_dut,
   input wire logic i_sdo,
   input wire logic i_sdo_oe,
   // Bench control
   input wire logic [7:0] i_tx,
   input wire logic i_go,
   input wire logic i_abort,
   // Lines towards the port
   output logic o_sck,
   output logic o_miso,
   output logic o_ss_b,
   output logic [7:0] o_rx
);
   // Half period kept above the slave's three-cycle floor
   localparam int HALF = 6;
   logic [7:0] sh_ff;   // Outgoing byte
   logic prev_ff;       // Last clock level seen
   logic run_ff;        // Frame in progress
   logic [4:0] tog_ff;  // Clock toggles so far
   logic [3:0] hc_ff;   // Cycles within a half period
   logic seen;
   logic rise;
   logic fall;
   assign seen = i_role_master ? o_sck : i_sck_dut;
   assign rise = seen && !prev_ff;
   assign fall = !seen && prev_ff;
   // Deselected line shows the inverse of its outgoing top bit, so no stale value passes
   assign o_miso = (i_role_master && o_ss_b) ? ~sh_ff[7] : sh_ff[7];
   initial begin
      o_sck = 1'b0;
      o_ss_b = 1'b1;
      o_rx = 8'h00;
      sh_ff = 8'h00;
      prev_ff = 1'b0;
      run_ff = 1'b0;
      tog_ff = 5'h00;
      hc_ff = 4'h0;
   end
   // Clock maker, shifter and sampler
   always @(posedge i_core_clk) begin
      prev_ff <= seen;
      if (i_go) begin
         sh_ff <= i_tx;
         if (i_role_master) begin
            o_ss_b <= 1'b0;
            run_ff <= 1'b1;
            tog_ff <= 5'h00;
            hc_ff <= 4'h0;
         end
      end else if (i_abort) begin
         o_ss_b <= 1'b1;
         run_ff <= 1'b0;
         o_sck <= 1'b0;
      end else begin
         // Sixteen toggles, clock back at idle low, then deselect
         if (run_ff) begin
            hc_ff <= (hc_ff == 4'(HALF - 1)) ? 4'h0 : hc_ff + 4'h1;
            if (hc_ff == 4'(HALF - 1) && tog_ff == 5'h10) begin
               run_ff <= 1'b0;
               o_ss_b <= 1'b1;
            end else if (hc_ff == 4'(HALF - 1)) begin
               o_sck <= ~o_sck;
               tog_ff <= tog_ff + 5'h01;
            end
         end
         // Sample on the leaving-idle edge, shift on the return edge
         if (rise) begin
            o_rx <= {o_rx[6:0], i_sdo_oe ? i_sdo : ~o_rx[0]};
         end
         if (fall) begin
            sh_ff <= {sh_ff[6:0], ~sh_ff[0]};
         end
      end
   end
endmodule : spi_far_end

// file: tb/sync_serial_port_test.sv
`timescale 1ns/1ns
module sync_serial_port_test;
   import sync_serial_pkg::*;
   // Bench drive
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, tmr_match = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_dat = 32'h0;
   logic [2:0] tmr_cnt = 3'h0;
   // Design outputs and partner lines
   logic wb_ack, sck, sck_oe, sdo, sdo_oe, int_flag, sck_line, sck_q;
   logic [31:0] wb_rdat;
   logic p_role = 1'b0, p_go = 1'b0, p_abort = 1'b0;
   logic p_sck, p_miso, p_ss_b;
   logic [7:0] p_tx = 8'h00;
   logic [7:0] p_rx;
   // Bookkeeping
   int failures = 0, checks = 0, seed = 65531, rises = 0, hi_cnt = 0;
   logic [31:0] rd, kept;
   logic [7:0] tx, ptx, b;
   logic [3:0] mode;
   localparam logic [3:0] MODES [5] = '{MODE_DIV4, MODE_DIV16, MODE_DIV64, MODE_BAUD, MODE_TMR};
   // Shared clock wire, resolved by the port's clock output enable
   assign sck_line = sck_oe ? sck : p_sck;
   sync_serial_port u_sync_serial_port (.i_core_clk(core_clk), .i_rst_b(rst_b),
      .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr),
      .i_wb_sel(wb_sel), .i_wb_dat(wb_dat), .o_wb_ack(wb_ack), .o_wb_dat(wb_rdat),
      .i_sck(sck_line), .o_sck(sck), .o_sck_oe(sck_oe), .i_sdi(p_miso), .o_sdo(sdo),
      .o_sdo_oe(sdo_oe), .i_ss_b(p_ss_b), .i_tmr_match(tmr_match),
      .o_port_int_flag(int_flag));
   spi_far_end u_spi_far_end (.i_core_clk(core_clk), .i_role_master(p_role),
      .i_sck_dut(sck_line), .i_sdo(sdo), .i_sdo_oe(sdo_oe), .i_tx(p_tx), .i_go(p_go),
      .i_abort(p_abort), .o_sck(p_sck), .o_miso(p_miso), .o_ss_b(p_ss_b), .o_rx(p_rx));
   initial forever #25 core_clk = ~core_clk;
   // Timer match pulse every fifth cycle
   always @(posedge core_clk) begin
      tmr_cnt <= (tmr_cnt == 3'h4) ? 3'h0 : tmr_cnt + 3'h1;
      tmr_match <= (tmr_cnt == 3'h4);
   end
   // Serial clock monitor: high cycles and rising edges, cleared by each partner load
   always @(posedge core_clk) begin
      sck_q <= sck;
      if (p_go) begin
         hi_cnt <= 0;
         rises <= 0;
      end else begin
         if (sck_oe && sck) hi_cnt <= hi_cnt + 1;
         if (sck && !sck_q) rises <= rises + 1;
      end
   end
   // Expected core cycles per half serial clock period
   function automatic int exp_half(input logic [3:0] m, input logic [7:0] bv);
      case (m)
         MODE_DIV16: exp_half = 8;
         MODE_DIV64: exp_half = 32;
         MODE_BAUD: exp_half = 2 * (bv + 1);
         MODE_TMR: exp_half = 5;
         default: exp_half = 2;
      endcase
   endfunction : exp_half
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic report_and_stop();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop
   task automatic timed_out();
      failures++;
      report_and_stop();
   endtask : timed_out
   // One classic cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat <= dat;
      wb_sel <= 4'hF;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      if (n >= 20) timed_out();
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge core_clk);
   endtask : wb
   task automatic wait_int();
      int n;
      n = 0;
      while (int_flag !== 1'b1 && n < 3000) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 3000) timed_out();
   endtask : wait_int
   // Pulse the partner's load for one clock edge
   task automatic load_partner(input logic [7:0] v);
      p_tx <= v;
      p_go <= 1'b1;
      @(posedge core_clk);
      p_go <= 1'b0;
   endtask : load_partner
   initial begin
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      // Reset values, status access kinds, unmapped place
      wb(1'b0, OFS_CTRL1, 32'h0);
      check("ctrl1_reset", rd, {24'h0, RST_BYTE});
      wb(1'b1, OFS_STATUS, 32'hFF);
      wb(1'b0, OFS_STATUS, 32'h0);
      check("status_rw", rd, 32'hC0);
      wb(1'b1, 8'h18, 32'h5A);
      wb(1'b0, 8'h18, 32'h0);
      check("unmapped", rd, 32'h0);
      // Master transfer at every rate
      for (int i = 0; i < 5; i++) begin
         mode = MODES[i];
         b = {6'h0, 2'($random(seed))};
         tx = 8'($random(seed));
         ptx = 8'($random(seed));
         wb(1'b1, OFS_CTRL1, 32'h0);
         wb(1'b1, OFS_CTRL3, {31'h0, mode == MODE_TMR});
         wb(1'b1, OFS_BAUD, {24'h0, b});
         wb(1'b1, OFS_STATUS, 32'h40);
         wb(1'b1, OFS_CTRL1, 32'h20 | {28'h0, mode});
         check("sck_oe_master", 32'(sck_oe), 32'h1);
         load_partner(ptx);
         wb(1'b1, OFS_BUF, {24'h0, tx});
         @(negedge core_clk);
         if (mode == MODE_TMR) check("sdo_oe_off", 32'(sdo_oe), 32'h0);
         else check("sdo_first", 32'(sdo), 32'(tx[7]));
         @(posedge core_clk);
         wb(1'b1, OFS_BUF, {24'h0, ~tx});
         if (mode == MODE_DIV64) begin
            wb(1'b0, OFS_BUF, 32'h0);
            check("buf_loaded", rd, {24'h0, tx});
         end
         wb(1'b0, OFS_CTRL1, 32'h0);
         check("collide_set", 32'(rd[C1_COLLIDE]), 32'h1);
         wait_int();
         check("sck_rises", 32'(rises), 32'h8);
         check("sck_high", 32'(hi_cnt), 32'(8 * exp_half(mode, b)));
         check("sck_idle", 32'(sck), 32'h0);
         wb(1'b0, OFS_STATUS, 32'h0);
         check("full_set", 32'(rd[STAT_FULL]), 32'h1);
         wb(1'b0, OFS_BUF, 32'h0);
         kept = rd;
         if (mode != MODE_DIV4) check("buf_rx", rd, {24'h0, ptx});
         if (mode != MODE_TMR) check("far_rx", {24'h0, p_rx}, {24'h0, tx});
         wb(1'b0, OFS_STATUS, 32'h0);
         check("full_clear", 32'(rd[STAT_FULL]), 32'h0);
         wb(1'b1, OFS_BUF, 32'h3C);
         wb(1'b0, OFS_BUF, 32'h0);
         check("buf_blocked", rd, kept);
         check("no_restart", 32'(rises), 32'h8);
         wb(1'b1, OFS_CTRL1, 32'h20 | {28'h0, mode});
         wb(1'b0, OFS_CTRL1, 32'h0);
         check("collide_clear", 32'(rd[C1_COLLIDE]), 32'h0);
         wb(1'b1, OFS_FLAGS, 32'h1);
         check("int_clear", 32'(int_flag), 32'h0);
      end
      // Slave with select control: aborted frame, then a whole one, then one more with select ignored
      p_role <= 1'b1;
      wb(1'b1, OFS_CTRL1, 32'h0);
      wb(1'b1, OFS_CTRL3, 32'h0);
      wb(1'b1, OFS_STATUS, 32'h40);
      wb(1'b1, OFS_CTRL1, 32'h20 | {28'h0, MODE_SLV_SS});
      check("slave_sck_in", 32'(sck_oe), 32'h0);
      check("unselected", 32'(sdo_oe), 32'h0);
      for (int k = 0; k < 3; k++) begin
         if (k == 2) begin
            // Same exchange again with the select pin ignored
            wb(1'b1, OFS_CTRL1, 32'h0);
            wb(1'b1, OFS_FLAGS, 32'h1);
            wb(1'b1, OFS_CTRL1, 32'h20 | {28'h0, MODE_SLV_NOSS});
            check("noss_drive", 32'(sdo_oe), 32'h1);
         end
         tx = 8'($random(seed));
         ptx = 8'($random(seed));
         wb(1'b1, OFS_BUF, {24'h0, tx});
         load_partner(ptx);
         if (k == 0) begin
            repeat (20) @(posedge core_clk);
            check("selected", 32'(sdo_oe), 32'h1);
            p_abort <= 1'b1;
            @(posedge core_clk);
            p_abort <= 1'b0;
            repeat (4) @(posedge core_clk);
            check("released", 32'(sdo_oe), 32'h0);
            check("no_int", 32'(int_flag), 32'h0);
         end else begin
            wait_int();
            wb(1'b0, OFS_BUF, 32'h0);
            check("slave_rx", rd, {24'h0, ptx});
            check("slave_tx", {24'h0, p_rx}, {24'h0, tx});
         end
      end
      report_and_stop();
   end
endmodule : sync_serial_port_test
